// File: rtl/usfs_pkg.sv
// Shared constants for the UART software flow, sleep and baud generator block.
// Assumes a 32-bit APB slave; registers take one aligned word each.
package usfs_pkg;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CHARS_OFS = 8'h04;
  localparam logic [7:0] DIV_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  // Control register fields
  localparam int RXFC_LO = 0;
  localparam int SLEEP_EFR_BIT = 4;
  localparam int SLEEP_IER_BIT = 5;
  localparam int PAUSE_IRQ_EN_BIT = 6;
  localparam int ANY_RESUME_BIT = 7;
  localparam int RESEND_EN_BIT = 8;
  localparam int RESEND_CNT_LO = 9;
  localparam int SPECIAL_EN_BIT = 11;
  localparam int PRESCALE_BIT = 12;
  // Status register fields
  localparam int ST_FLOW_BIT = 0;
  localparam int ST_IRQ_BIT = 1;
  localparam int ST_SLEEP_BIT = 2;
  localparam int ST_SPECIAL_BIT = 3;
  localparam int ST_TXEMPTY_BIT = 4;
  localparam int ST_THREMPTY_BIT = 5;
  localparam logic [1:0] RXFC_OFF = 2'h0;
  localparam logic [1:0] RXFC_SECOND = 2'h1;
  localparam logic [1:0] RXFC_FIRST = 2'h2;
  localparam logic [1:0] RXFC_PAIR = 2'h3;
  localparam logic [12:0] CTRL_RESET = 13'h0000;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [7:0] PRESCALE_SLOW = 8'h04;
endpackage

// File: rtl/usfs_baud_gen.sv
// Baud generator: prescaler by 1 or 4 then 16-bit divisor, 16x sample tick.
// Assumes a divisor of zero means no tick at all.
`timescale 1ns/1ns
module usfs_baud_gen #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Control
  input wire logic run,
  input wire logic prescaleBy4,
  input wire logic [DIV_W-1:0] divisor,
  // Tick out
  output logic sampleTick
);
  logic [7:0] preCnt_r;
  logic [DIV_W-1:0] divCnt_r;
  wire preTick = !prescaleBy4 || (preCnt_r == usfs_pkg::PRESCALE_SLOW - 8'h01);
  wire divZero = (divisor == '0);
  wire divWrap = (divCnt_r >= divisor - {{(DIV_W-1){1'b0}}, 1'b1});
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      preCnt_r <= 8'h00;
      divCnt_r <= '0;
      sampleTick <= 1'b0;
    end else begin
      // Stopped clocks while asleep: counters hold so wake resumes cleanly
      sampleTick <= run && !divZero && preTick && divWrap;
      if (run && prescaleBy4) begin
        preCnt_r <= preTick ? 8'h00 : preCnt_r + 8'h01;
      end
      if (run && !divZero && preTick) begin
        divCnt_r <= divWrap ? '0 : divCnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// File: rtl/usfs_top.sv
// UART receive software flow control, pause resend, sleep control and baud clock.
// Assumes received characters arrive as one-cycle strobes from a receiver.
// Overview of operation
// - Flow status bit reports resume (0) or pause (1) while receive flow control on.
// - Pause character raises enabled interrupt; cleared by status read or resume char.
// - Transmit-empty bits follow FIFO free space only, never the pause state.
// - Flow characters with parity errors are still recognised.
// - Single mode with equal resume and pause characters treats all as resume.
// - Repeated first characters then second completes pair; broken interleaves do nothing.
// - Orphan second character is stored as data; unpaired first character is dropped.
// - All four equal, or pairs equal, recognise resume only; else both.
// - Any-resume option moves pause to resume state on any character.
// - Any-resume single mode: pause char in pause state resumes, not stored.
// - Any-resume pair mode: lone second resume char resumes and is stored.
// - Any-resume pair mode: pause pair in pause state resumes then pauses.
// - Special detection uses second pause value when only first pause is flow char.
// - Without resend, a threshold pause is sent only once.
// - Resend pause every 1, 4, 8 or 16 characters arriving after a pause was sent.
// - Sleep only when both sleep enable bits are set.
// - Sleep only when line idle, modem steady, transmit empty, no pending interrupt.
// - Sleep holds the baud generator and stops its sample tick.
// - Wake on start bit, transmit write, or modem input change.
// - Prescaler divides input clock by 1 or 4.
// - Sixteen-bit divisor makes the 16x sample tick.
// - Prescaler bit loads divide-by-1 if select pin high, else divide-by-4.
// - Divisor of zero generates no baud clock.
// - Two-bit enable field 01, 10, 11 picks characters compared.
// - On pause, transmitter finishes the current character then stops.
`timescale 1ns/1ns
module usfs_top #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receiver character stream
  input wire logic rxValid,
  input wire logic [7:0] rxChar,
  input wire logic rxParityErr,
  input wire logic rxLineIdle,
  input wire logic rxStartEdge,
  // Transmit side status
  input wire logic txFifoHasSpace,
  input wire logic txFifoEmpty,
  input wire logic txShiftEmpty,
  input wire logic txShiftBusy,
  input wire logic txWrite,
  input wire logic txUpperCrossed,
  input wire logic txPauseSent,
  // Modem and pending interrupt status
  input wire logic [3:0] modemIn,
  input wire logic otherIrqPending,
  input wire logic prescale_select_pin,
  // Outputs to rest of channel
  output logic rxStore,
  output logic [7:0] rxStoreChar,
  output logic txSuspend,
  output logic sendPauseReq,
  output logic flowIrq,
  output logic specialDetect,
  output logic asleep,
  output logic sampleTick
);
  typedef enum logic [1:0] {USFS_IDLE, USFS_ONE, USFS_PF} usfs_pend_e;
  logic [12:0] ctrl_r;
  logic [31:0] chars_r;
  logic [15:0] div_r;
  logic flow_r, flow_nxt;
  logic irq_r, irq_nxt;
  logic special_r;
  usfs_pend_e pend_r, pend_nxt;
  logic [7:0] pendChar_r, pendChar_nxt;
  logic pendIsPause_r, pendIsPause_nxt;
  logic storePrev_r;
  logic [4:0] resendCnt_r;
  logic pauseSentOnce_r;
  logic prescaleCaught_r;
  logic [3:0] modemPrev_r;
  logic sleep_r;
  logic txSuspend_r;
  logic store_nxt;
  logic pendStore;
  logic pauseSeen;
  wire [7:0] resumeA = chars_r[7:0];
  wire [7:0] resumeB = chars_r[15:8];
  wire [7:0] pauseA = chars_r[23:16];
  wire [7:0] pauseB = chars_r[31:24];
  wire [1:0] rxMode = ctrl_r[usfs_pkg::RXFC_LO +: 2];
  wire rxOn = rxMode != usfs_pkg::RXFC_OFF;
  wire anyResume = ctrl_r[usfs_pkg::ANY_RESUME_BIT];
  wire pairMode = rxMode == usfs_pkg::RXFC_PAIR;
  wire [7:0] singleResume = rxMode == usfs_pkg::RXFC_FIRST ? resumeA : resumeB;
  wire [7:0] singlePause = rxMode == usfs_pkg::RXFC_FIRST ? pauseA : pauseB;
  // Parity error is deliberately ignored in matching
  wire unusedParity = rxParityErr;
  wire sResume = rxChar == singleResume;
  wire sPause = (rxChar == singlePause) && !(singlePause == singleResume);
  wire pairsEqual = (resumeA == pauseA) && (resumeB == pauseB);
  wire pauseAllowed = !pairsEqual;
  wire isResA = rxChar == resumeA;
  wire isResB = rxChar == resumeB;
  wire isPauA = (rxChar == pauseA) && pauseAllowed;
  wire isPauB = (rxChar == pauseB) && pauseAllowed;
  wire pendRes = pend_r == USFS_ONE && !pendIsPause_r;
  wire pendPau = pend_r == USFS_ONE && pendIsPause_r;
  wire pairResume = pendRes && isResB;
  wire pairPause = pendPau && isPauB;
  wire apbSetup = psel && !penable;
  wire apbWr = psel && penable && pwrite;
  wire apbRd = psel && penable && !pwrite;
  wire addrOk = paddr == usfs_pkg::CTRL_OFS || paddr == usfs_pkg::CHARS_OFS ||
                paddr == usfs_pkg::DIV_OFS || paddr == usfs_pkg::STAT_OFS;
  wire statRead = apbRd && paddr == usfs_pkg::STAT_OFS;
  wire sleepEn = ctrl_r[usfs_pkg::SLEEP_EFR_BIT] && ctrl_r[usfs_pkg::SLEEP_IER_BIT];
  wire modemChange = modemIn != modemPrev_r;
  wire wake = rxStartEdge || txWrite || modemChange;
  wire sleepOk = sleepEn && rxLineIdle && !modemChange && txFifoEmpty && txShiftEmpty &&
                 !otherIrqPending && !irq_r;
  wire resendEn = ctrl_r[usfs_pkg::RESEND_EN_BIT];
  wire [1:0] resendSel = ctrl_r[usfs_pkg::RESEND_CNT_LO +: 2];
  wire [4:0] resendLimit = resendLimitOf(resendSel);
  wire specialOn = ctrl_r[usfs_pkg::SPECIAL_EN_BIT] && rxMode == usfs_pkg::RXFC_FIRST;

  function automatic logic [4:0] resendLimitOf(input logic [1:0] sel);
    unique case (sel)
      2'h0: resendLimitOf = 5'h01;
      2'h1: resendLimitOf = 5'h04;
      2'h2: resendLimitOf = 5'h08;
      2'h3: resendLimitOf = 5'h10;
    endcase
  endfunction

  // Receive character decode; pend state holds a first character awaiting its partner
  always_comb begin
    flow_nxt = flow_r;
    irq_nxt = irq_r && !statRead;
    pend_nxt = pend_r;
    pendChar_nxt = pendChar_r;
    pendIsPause_nxt = pendIsPause_r;
    store_nxt = 1'b0;
    pendStore = 1'b0;
    pauseSeen = 1'b0;
    if (rxValid && !rxOn) begin
      store_nxt = 1'b1;
    end else if (rxValid && !pairMode) begin
      if (sResume) begin
        flow_nxt = 1'b0;
      end else if (sPause) begin
        pauseSeen = 1'b1;
        flow_nxt = anyResume ? !flow_r : 1'b1;
      end else begin
        store_nxt = 1'b1;
        if (anyResume) begin
          flow_nxt = 1'b0;
        end
      end
    end else if (rxValid) begin
      pend_nxt = USFS_IDLE;
      if (pairResume) begin
        flow_nxt = 1'b0;
      end else if (pairPause) begin
        pauseSeen = 1'b1;
        flow_nxt = 1'b1;
      end else if (isResA || isPauA) begin
        // Interleaved first characters cancel each other and are dropped
        if (pend_r == USFS_ONE && pendChar_r != rxChar) begin
          pend_nxt = USFS_PF;
        end else begin
          // A repeated first character replaces the earlier one, which is dropped
          pendStore = 1'b0;
          pend_nxt = USFS_ONE;
        end
        pendChar_nxt = rxChar;
        pendIsPause_nxt = !isResA;
        if (anyResume && flow_r) begin
          flow_nxt = 1'b0;
        end
      end else begin
        store_nxt = 1'b1;
        if (anyResume && flow_r) begin
          flow_nxt = 1'b0;
        end
      end
    end
    // Every recognised pause that leaves flow paused raises the enabled interrupt, even when already paused
    if (flow_nxt && (!flow_r || pauseSeen) && ctrl_r[usfs_pkg::PAUSE_IRQ_EN_BIT]) begin
      irq_nxt = 1'b1;
    end else if (rxValid && !flow_nxt) begin
      irq_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= usfs_pkg::CTRL_RESET;
      chars_r <= 32'h00000000;
      div_r <= usfs_pkg::DIV_RESET;
      prescaleCaught_r <= 1'b0;
    end else begin
      if (!prescaleCaught_r) begin
        ctrl_r[usfs_pkg::PRESCALE_BIT] <= !prescale_select_pin;
        prescaleCaught_r <= 1'b1;
      end else if (apbWr && paddr == usfs_pkg::CTRL_OFS) begin
        ctrl_r <= pwdata[12:0];
      end
      if (apbWr && paddr == usfs_pkg::CHARS_OFS) begin
        chars_r <= pwdata;
      end
      if (apbWr && paddr == usfs_pkg::DIV_OFS) begin
        div_r <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flow_r <= 1'b0;
      irq_r <= 1'b0;
      pend_r <= USFS_IDLE;
      pendChar_r <= 8'h00;
      pendIsPause_r <= 1'b0;
      storePrev_r <= 1'b0;
    end else begin
      flow_r <= rxOn ? flow_nxt : 1'b0;
      irq_r <= irq_nxt;
      pend_r <= pend_nxt;
      pendChar_r <= pendChar_nxt;
      pendIsPause_r <= pendIsPause_nxt;
      if (rxValid) begin
        storePrev_r <= pend_nxt == USFS_ONE;
      end
    end
  end

  // Data path to the receive FIFO; an unpaired first char is never released
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxStore <= 1'b0;
      rxStoreChar <= 8'h00;
      special_r <= 1'b0;
      specialDetect <= 1'b0;
    end else begin
      rxStore <= store_nxt || pendStore;
      rxStoreChar <= pendStore ? pendChar_r : rxChar;
      special_r <= rxValid && specialOn && rxChar == pauseB && rxChar != pauseA;
      specialDetect <= special_r;
    end
  end

  // Pause resend counting and transmit suspension
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      resendCnt_r <= 5'h00;
      pauseSentOnce_r <= 1'b0;
      sendPauseReq <= 1'b0;
      txSuspend_r <= 1'b0;
    end else begin
      if (txPauseSent) begin
        pauseSentOnce_r <= 1'b1;
      end else if (!txUpperCrossed) begin
        pauseSentOnce_r <= 1'b0;
      end
      if (!pauseSentOnce_r || !resendEn || !rxValid) begin
        sendPauseReq <= txUpperCrossed && !pauseSentOnce_r && !txPauseSent;
        if (!pauseSentOnce_r) begin
          resendCnt_r <= 5'h00;
        end
      end else if (resendCnt_r + 5'h01 >= resendLimit) begin
        sendPauseReq <= 1'b1;
        resendCnt_r <= 5'h00;
      end else begin
        sendPauseReq <= 1'b0;
        resendCnt_r <= resendCnt_r + 5'h01;
      end
      // Wait for the shifter to go idle so the current character completes
      if (!flow_r) begin
        txSuspend_r <= 1'b0;
      end else if (!txShiftBusy) begin
        txSuspend_r <= 1'b1;
      end
    end
  end

  // Sleep control and APB answer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_r <= 1'b0;
      modemPrev_r <= 4'h0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      txSuspend <= 1'b0;
      flowIrq <= 1'b0;
      asleep <= 1'b0;
    end else begin
      modemPrev_r <= modemIn;
      if (wake || !sleepEn) begin
        sleep_r <= 1'b0;
      end else if (sleepOk) begin
        sleep_r <= 1'b1;
      end
      asleep <= sleep_r;
      txSuspend <= txSuspend_r;
      flowIrq <= irq_r;
      pready <= apbSetup;
      pslverr <= apbSetup && !addrOk;
      if (apbSetup) begin
        unique case (paddr)
          usfs_pkg::CTRL_OFS: prdata <= {19'h00000, ctrl_r};
          usfs_pkg::CHARS_OFS: prdata <= chars_r;
          usfs_pkg::DIV_OFS: prdata <= {16'h0000, div_r};
          usfs_pkg::STAT_OFS: prdata <= {26'h0000000, txFifoHasSpace, txFifoHasSpace,
                                          specialDetect, sleep_r, irq_r, flow_r};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  usfs_baud_gen #(
    .DIV_W(DIV_W)
  ) baudGen (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .run(!sleep_r),
    .prescaleBy4(ctrl_r[usfs_pkg::PRESCALE_BIT]),
    .divisor(div_r[DIV_W-1:0]),
    .sampleTick(sampleTick)
  );
endmodule

// File: test/usfs_remote.sv
// Remote UART model: delivers each received character as a one-cycle strobe.
// Assumes the bench requests one character at a time through go.
`timescale 1ns/1ns
module usfs_remote (
  // Clock
  input wire logic sys_clk,
  // Request from bench
  input wire logic go,
  input wire logic [7:0] ch,
  input wire logic perr,
  // Character stream
  output logic rxValid,
  output logic [7:0] rxChar,
  output logic rxParityErr
);
  initial begin
    rxValid = 1'b0;
    rxChar = 8'h00;
    rxParityErr = 1'b0;
  end
  // Between strobes the data is scrambled so nothing can lean on a stale char
  always @(posedge sys_clk) begin
    rxValid <= go;
    rxChar <= go ? ch : ~rxChar;
    rxParityErr <= go ? perr : 1'b0;
  end
endmodule

// File: test/usfs_top_assertions.sv
// Checker for the flow, sleep and baud block, bound to its top module.
// Assumes a single clock domain and write shadows taken from completed APB cycles.
`timescale 1ns/1ns
module usfs_top_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Channel inputs
  input wire logic rxValid,
  input wire logic rxStartEdge,
  input wire logic txWrite,
  input wire logic txFifoHasSpace,
  input wire logic txFifoEmpty,
  input wire logic txShiftEmpty,
  input wire logic rxLineIdle,
  input wire logic otherIrqPending,
  // Block outputs
  input wire logic rxStore,
  input wire logic flowIrq,
  input wire logic specialDetect,
  input wire logic asleep,
  input wire logic sampleTick
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] divShadow_r;
  logic [12:0] ctrlShadow_r;
  wire wrDone = psel && penable && pready && pwrite;
  wire statRead = psel && pready && !pwrite && paddr == usfs_pkg::STAT_OFS;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      divShadow_r <= usfs_pkg::DIV_RESET;
      ctrlShadow_r <= usfs_pkg::CTRL_RESET;
    end else if (wrDone && paddr == usfs_pkg::DIV_OFS) begin
      divShadow_r <= pwdata[15:0];
    end else if (wrDone && paddr == usfs_pkg::CTRL_OFS) begin
      ctrlShadow_r <= pwdata[12:0];
    end
  end
  chk_apb_answer: assert property (psel && !penable |=> pready) else $error("no ready in access");
  chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  chk_tx_empty: assert property (statRead && $stable(txFifoHasSpace) |->
    prdata[5:4] == {2{txFifoHasSpace}}) else $error("tx empty bits wrong");
  chk_zero_div: assert property (divShadow_r == 16'h0000 && $past(divShadow_r) == 16'h0000
    && $past(divShadow_r, 2) == 16'h0000 |-> !sampleTick) else $error("tick with zero divisor");
  chk_sleep_quiet: assert property (asleep && $past(asleep) |-> !sampleTick) else $error("tick asleep");
  chk_sleep_enable: assert property ($rose(asleep) |-> ctrlShadow_r[5:4] == 2'h3)
    else $error("sleep without enables");
  chk_sleep_cond: assert property ($rose(asleep) |->
    $past(rxLineIdle && txFifoEmpty && txShiftEmpty && !otherIrqPending)) else $error("sleep while busy");
  chk_wake_up: assert property (asleep && (rxStartEdge || txWrite) |-> ##[1:2] !asleep)
    else $error("no wake");
  chk_irq_clear: assert property (statRead && !rxValid && !$past(rxValid) && !$past(rxValid, 2)
    |-> ##2 !flowIrq) else $error("irq not cleared");
  chk_special_lag: assert property (specialDetect |-> $past(rxValid, 2)) else $error("stray special");
  chk_store_lag: assert property (rxStore |-> $past(rxValid)) else $error("stray store");
endmodule
bind usfs_top usfs_top_chk usfs_top_chk_i (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .rxValid, .rxStartEdge, .txWrite, .txFifoHasSpace, .txFifoEmpty,
  .txShiftEmpty, .rxLineIdle, .otherIrqPending, .rxStore, .flowIrq, .specialDetect, .asleep, .sampleTick);

// File: test/uart_swflow_sleep_baudgen_bench.sv
// Self-checking bench for the flow, sleep and baud block.
// Assumes the remote model feeds characters and the bench plays APB master.
`timescale 1ns/1ns
module uart_swflow_sleep_baudgen_bench;
  logic sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic go = 1'b0, goPerr = 1'b0, rxLineIdle = 1'b1, rxStartEdge = 1'b0, txWrite = 1'b0;
  logic txFifoHasSpace = 1'b1, txFifoEmpty = 1'b1, txShiftEmpty = 1'b1, txShiftBusy = 1'b0;
  logic txUpperCrossed = 1'b0, txPauseSent = 1'b0, otherIrqPending = 1'b0, prescale_select_pin = 1'b0;
  logic [3:0] modemIn = 4'h0;
  logic [7:0] paddr = 8'h00, goChar = 8'h00, rxChar, rxStoreChar, lastStore;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic rxValid, rxParityErr, pready, pslverr, rxStore, txSuspend, sendPauseReq, flowIrq;
  logic specialDetect, asleep, sampleTick, rdErr;
  int error_cnt = 0, cmp_count = 0, storeCnt = 0, specCnt = 0, pauseCnt = 0;
  always #4 sys_clk = ~sys_clk;
  usfs_top usfs_top_i (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rxValid, .rxChar, .rxParityErr, .rxLineIdle, .rxStartEdge, .txFifoHasSpace, .txFifoEmpty,
    .txShiftEmpty, .txShiftBusy, .txWrite, .txUpperCrossed, .txPauseSent, .modemIn, .otherIrqPending,
    .prescale_select_pin, .rxStore, .rxStoreChar, .txSuspend, .sendPauseReq, .flowIrq, .specialDetect,
    .asleep, .sampleTick);
  usfs_remote usfs_remote_i (.sys_clk, .go, .ch(goChar), .perr(goPerr), .rxValid, .rxChar, .rxParityErr);
  always @(posedge sys_clk) begin
    if (rxStore === 1'b1) begin
      storeCnt++;
      lastStore = rxStoreChar;
    end
    if (specialDetect === 1'b1) specCnt++;
    if (sendPauseReq === 1'b1) pauseCnt++;
  end
  task automatic finish_test;
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      finish_test();
    end
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic stat(input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, usfs_pkg::STAT_OFS, 32'h0);
    chk(rd & mask, exp);
  endtask
  // Fixed settle time covers strobe, store and flow-state latency
  task automatic send(input logic [7:0] c, input logic pe);
    go <= 1'b1;
    goChar <= c;
    goPerr <= pe;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic t_reset;
    for (int p = 0; p < 2; p++) begin
      reset_n <= 1'b0;
      prescale_select_pin <= p[0];
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      apb(1'b0, usfs_pkg::CTRL_OFS, 32'h0);
      chk(rd, {19'h0, ~p[0], 12'h000});
    end
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, rdErr}, 32'h1);
    txFifoHasSpace <= 1'b0;
    stat(32'h30, 32'h00);
    txFifoHasSpace <= 1'b1;
  endtask
  task automatic t_single;
    apb(1'b1, usfs_pkg::CHARS_OFS, 32'h00130011);
    apb(1'b1, usfs_pkg::CTRL_OFS, 32'h00000042);
    send(8'h13, 1'b1);
    chk({31'h0, txSuspend}, 32'h1);
    stat(32'h33, 32'h33);
    stat(32'h02, 32'h00);
    send(8'h13, 1'b0);
    chk({31'h0, flowIrq}, 32'h1);
    send(8'h11, 1'b0);
    chk({31'h0, flowIrq}, 32'h0);
    stat(32'h01, 32'h00);
    send(8'h41, 1'b0);
    chk({24'h0, lastStore}, 32'h41);
    chk(32'(storeCnt), 32'h1);
    send(8'h13, 1'b0);
    apb(1'b1, usfs_pkg::CHARS_OFS, 32'h00110011);
    send(8'h11, 1'b0);
    stat(32'h01, 32'h00);
  endtask
  task automatic t_pair;
    int s;
    s = storeCnt;
    apb(1'b1, usfs_pkg::CTRL_OFS, 32'h00000003);
    apb(1'b1, usfs_pkg::CHARS_OFS, 32'h14131211);
    send(8'h13, 1'b0);
    send(8'h13, 1'b0);
    send(8'h14, 1'b0);
    stat(32'h01, 32'h01);
    send(8'h12, 1'b0);
    chk({24'h0, lastStore}, 32'h12);
    send(8'h11, 1'b0);
    send(8'h12, 1'b0);
    stat(32'h01, 32'h00);
    chk(32'(storeCnt), 32'(s + 1));
    apb(1'b1, usfs_pkg::CHARS_OFS, 32'h13111311);
    send(8'h11, 1'b0);
    send(8'h13, 1'b0);
    stat(32'h01, 32'h00);
  endtask
  task automatic t_any;
    int s;
    s = storeCnt;
    apb(1'b1, usfs_pkg::CTRL_OFS, 32'h00000082);
    apb(1'b1, usfs_pkg::CHARS_OFS, 32'h00130011);
    send(8'h13, 1'b0);
    stat(32'h01, 32'h01);
    send(8'h55, 1'b0);
    stat(32'h01, 32'h00);
    send(8'h13, 1'b0);
    send(8'h13, 1'b0);
    stat(32'h01, 32'h00);
    chk(32'(storeCnt), 32'(s + 1));
  endtask
  task automatic t_special;
    int s;
    apb(1'b1, usfs_pkg::CTRL_OFS, 32'h00000802);
    apb(1'b1, usfs_pkg::CHARS_OFS, 32'h14130011);
    s = specCnt;
    send(8'h14, 1'b0);
    chk(32'(specCnt), 32'(s + 1));
    txUpperCrossed <= 1'b1;
    txPauseSent <= 1'b1;
    @(posedge sys_clk);
    txPauseSent <= 1'b0;
    s = pauseCnt;
    send(8'h41, 1'b0);
    send(8'h42, 1'b0);
    chk(32'(pauseCnt), 32'(s));
    txUpperCrossed <= 1'b0;
  endtask
  // Skips one tick so a divisor change cannot distort the measured gap
  task automatic tick_gap(input int exp);
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (sampleTick !== 1'b1 && n < 200);
    end
    chk(32'(n), 32'(exp));
  endtask
  task automatic t_baud;
    int n;
    apb(1'b1, usfs_pkg::CTRL_OFS, 32'h0);
    apb(1'b1, usfs_pkg::DIV_OFS, 32'h3);
    tick_gap(3);
    apb(1'b1, usfs_pkg::CTRL_OFS, 32'h00001000);
    tick_gap(12);
    apb(1'b1, usfs_pkg::DIV_OFS, 32'h0);
    n = 0;
    repeat (100) begin
      @(posedge sys_clk);
      if (sampleTick === 1'b1) n++;
    end
    chk(32'(n), 32'h0);
  endtask
  task automatic sleep_chk(input logic want, input logic exp);
    int n;
    n = 0;
    while (asleep !== want && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, asleep}, {31'h0, exp});
  endtask
  task automatic t_sleep;
    apb(1'b1, usfs_pkg::CTRL_OFS, 32'h00000030);
    apb(1'b1, usfs_pkg::DIV_OFS, 32'h3);
    sleep_chk(1'b1, 1'b1);
    stat(32'h04, 32'h04);
    rxLineIdle <= 1'b0;
    rxStartEdge <= 1'b1;
    @(posedge sys_clk);
    rxStartEdge <= 1'b0;
    sleep_chk(1'b0, 1'b0);
    rxLineIdle <= 1'b1;
    sleep_chk(1'b1, 1'b1);
    txFifoEmpty <= 1'b0;
    txWrite <= 1'b1;
    @(posedge sys_clk);
    txWrite <= 1'b0;
    sleep_chk(1'b0, 1'b0);
    apb(1'b1, usfs_pkg::CTRL_OFS, 32'h00000010);
    txFifoEmpty <= 1'b1;
    sleep_chk(1'b1, 1'b0);
  endtask
  initial begin
    t_reset();
    t_single();
    t_pair();
    t_any();
    t_special();
    t_baud();
    t_sleep();
    finish_test();
  end
endmodule
